//--- dap_defs.svh
`ifndef DAP_DEFS_SVH
`define DAP_DEFS_SVH

// ----------------------------------------
// Conversion path
// ----------------------------------------
`define DAP_WORD_W 10
`define DAP_LATENCY 5
`define DAP_MSB 9
`define DAP_SYNC_N 4
// Pin sync bit positions
`define DAP_PIN_FMT 0
`define DAP_PIN_SLEEP 1
`define DAP_PIN_PD 2
`define DAP_PIN_OEN 3
`define DAP_PIN_RST 4'h8

// ----------------------------------------
// Register map
// ----------------------------------------
`define DAP_ADDR_W 4
`define DAP_OFF_CTRL 4'h0
`define DAP_OFF_STATUS 4'h4
`define DAP_OFF_DATA 4'h8
`define DAP_CTRL_RST 2'h0
`define DAP_CTRL_SLEEP 0
`define DAP_CTRL_PD 1
`define DAP_DATA_B_LSB 16
`define DAP_RESP_OKAY 2'h0
`define DAP_RESP_SLVERR 2'h2

`endif

//--- dap_pkg.sv
package dap_pkg;
  typedef logic [9:0] dap_word_t;
  typedef struct packed {
    logic valid;
    dap_word_t a;
    dap_word_t b;
  } dap_pair_t;
endpackage

//--- dap_top.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "dap_defs.svh"

// Summary of operation
// - Both channels are sampled together on every rising clock edge while power-down is inactive.
// - A sample's word reaches the output buses five cycles after capture.
// - Words change after a rising edge and are valid at the next one.
// - Each channel has its own 10-bit bus with bit 9 as the MSB.
// - Format low gives straight offset binary coding.
// - Format high gives two's complement coding.
// - Output enable low-active; high puts both buses in high impedance.
// - Power-down with outputs enabled holds every bit at its last value.
// - Sleep stops both converters so no new words are produced.
// - With output enable low the buses are actively driven.
// - With power-down and sleep low a conversion occurs every cycle.
module dap_top (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [9:0] chan_a_sample_in,
  input wire logic [9:0] chan_b_sample_in,
  input wire logic format_sel_in,
  input wire logic sleep_in,
  input wire logic power_down_in,
  input wire logic output_enable_n_in,
  output logic [9:0] chan_a_word_out,
  output logic [9:0] chan_a_word_oe_out,
  output logic [9:0] chan_b_word_out,
  output logic [9:0] chan_b_word_oe_out,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic dap_pkg::dap_word_t code_word(
    input dap_pkg::dap_word_t raw, input logic twos);
    code_word = raw;
    if (twos) begin
      code_word[`DAP_MSB] = ~raw[`DAP_MSB];
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] pin_reg;
  localparam logic [3:0] PIN_RST = `DAP_PIN_RST;

  assign pin_raw = {output_enable_n_in, power_down_in, sleep_in,
                    format_sel_in};

  genvar gi;
  generate
    for (gi = 0; gi < `DAP_SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          s1_reg[gi] <= PIN_RST[gi];
          s2_reg[gi] <= PIN_RST[gi];
          s3_reg[gi] <= PIN_RST[gi];
          pin_reg[gi] <= PIN_RST[gi];
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            pin_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic [1:0] ctrl_reg;
  logic fmt_twos;
  logic sleep_eff;
  logic pd_eff;
  logic oen_eff;
  logic run;

  assign fmt_twos = pin_reg[`DAP_PIN_FMT];
  assign sleep_eff = pin_reg[`DAP_PIN_SLEEP] | ctrl_reg[`DAP_CTRL_SLEEP];
  assign pd_eff = pin_reg[`DAP_PIN_PD] | ctrl_reg[`DAP_CTRL_PD];
  assign oen_eff = pin_reg[`DAP_PIN_OEN];
  assign run = !sleep_eff && !pd_eff;

  // ----------------------------------------
  // Conversion pipeline
  // ----------------------------------------
  dap_pkg::dap_pair_t pipe_reg [0:`DAP_LATENCY-1];
  dap_pkg::dap_pair_t out_reg;
  dap_pkg::dap_pair_t take;

  assign take = '{valid: run, a: chan_a_sample_in, b: chan_b_sample_in};

  generate
    for (gi = 0; gi < `DAP_LATENCY; gi++) begin : g_pipe
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pipe_reg[gi] <= '0;
        end else if (!pd_eff) begin
          if (gi == 0) begin
            pipe_reg[gi] <= take;
          end else begin
            pipe_reg[gi] <= pipe_reg[(gi > 0) ? gi - 1 : 0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out_reg <= '0;
    end else if (!pd_eff && pipe_reg[`DAP_LATENCY-1].valid) begin
      out_reg.valid <= 1'b1;
      out_reg.a <= code_word(pipe_reg[`DAP_LATENCY-1].a, fmt_twos);
      out_reg.b <= code_word(pipe_reg[`DAP_LATENCY-1].b, fmt_twos);
    end
  end

  assign chan_a_word_out = out_reg.a;
  assign chan_b_word_out = out_reg.b;
  assign chan_a_word_oe_out = {`DAP_WORD_W{!oen_eff}};
  assign chan_b_word_oe_out = {`DAP_WORD_W{!oen_eff}};

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic wr_ctrl;
  logic rd_hit;
  logic [31:0] rd_word;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_ctrl = wr_go && (awaddr_reg == `DAP_OFF_CTRL);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rd_hit = (s_axi_araddr == `DAP_OFF_CTRL) ||
                  (s_axi_araddr == `DAP_OFF_STATUS) ||
                  (s_axi_araddr == `DAP_OFF_DATA);
  assign rd_word =
    (s_axi_araddr == `DAP_OFF_CTRL) ? {30'h0, ctrl_reg} :
    (s_axi_araddr == `DAP_OFF_STATUS) ?
      {25'h0, out_reg.valid, run, pin_reg, 1'b0} :
    (s_axi_araddr == `DAP_OFF_DATA) ?
      {6'h0, out_reg.b, 6'h0, out_reg.a} : 32'h0;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DAP_RESP_OKAY;
      ctrl_reg <= `DAP_CTRL_RST;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ctrl ? `DAP_RESP_OKAY : `DAP_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (wr_ctrl && wstrb0_reg) begin
        ctrl_reg <= wdata_reg[1:0];
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `DAP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? `DAP_RESP_OKAY : `DAP_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  property p_latency_bin;
    (run && !fmt_twos) [*7] |->
      chan_a_word_out == $past(chan_a_sample_in, 6);
  endproperty
  a_latency_bin: assert property (p_latency_bin)
    else $error("channel A word not five cycles behind its sample");
  property p_latency_twos;
    (run && fmt_twos) [*7] |-> chan_b_word_out ==
      {~$past(chan_b_sample_in[9], 6), $past(chan_b_sample_in[8:0], 6)};
  endproperty
  a_latency_twos: assert property (p_latency_twos)
    else $error("channel B two's complement word wrong");
  property p_simultaneous;
    pipe_reg[0].valid && !$past(pd_eff) |->
      pipe_reg[0].a == $past(chan_a_sample_in) &&
      pipe_reg[0].b == $past(chan_b_sample_in);
  endproperty
  a_simultaneous: assert property (p_simultaneous)
    else $error("channels not captured on the same edge");
  property p_hiz;
    oen_eff |-> (chan_a_word_oe_out | chan_b_word_oe_out) == 10'h000;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("buses driven while output enable is high");
  property p_drive;
    !oen_eff |-> (chan_a_word_oe_out & chan_b_word_oe_out) == 10'h3ff;
  endproperty
  a_drive: assert property (p_drive)
    else $error("buses not driven while output enable is low");
  property p_pd_hold;
    pd_eff |=> $stable(chan_a_word_out) && $stable(chan_b_word_out);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("output changed during power-down");
  property p_sleep;
    sleep_eff [*6] |=> $stable(chan_a_word_out) &&
      $stable(chan_b_word_out);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("new word produced while asleep");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data dropped before taken");

endmodule // dap_top

//--- dap_capture.sv
`timescale 1ns/100ps
// ----------------------------------------
// Capture side of one parallel bus
// ----------------------------------------
module dap_capture (
  input wire logic clock_in,
  input wire logic [9:0] word_in,
  input wire logic [9:0] word_oe_in,
  output logic [9:0] line_out,
  output logic [9:0] captured_out
);
  logic [9:0] last_reg = 10'h000;
  // Released bits toggle, never keep a stale value
  assign line_out = (word_in & word_oe_in) | (~last_reg & ~word_oe_in);
  always @(posedge clock_in) begin
    last_reg <= line_out;
    captured_out <= line_out;
  end
endmodule // dap_capture

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clock_in = 0, resetn_in = 0, format_sel_in = 0, sleep_in = 0;
  logic power_down_in = 0, output_enable_n_in = 1;
  dap_pkg::dap_word_t chan_a_sample_in = 0, chan_b_sample_in = 0;
  logic [9:0] chan_a_word_out, chan_a_word_oe_out;
  logic [9:0] chan_b_word_out, chan_b_word_oe_out;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] line_a, line_b, cap_a, cap_b;
  int miscompares = 0, tests_run = 0, cycles = 0;
  dap_pkg::dap_word_t tbl[8] = '{10'h000, 10'h200, 10'h3ff, 10'h001,
    10'h1ff, 10'h201, 10'h3fe, 10'h155};
  always #2.5 clock_in = ~clock_in;
  dap_top dap_top_inst (.clock_in, .resetn_in, .chan_a_sample_in,
    .chan_b_sample_in, .format_sel_in, .sleep_in, .power_down_in,
    .output_enable_n_in, .chan_a_word_out, .chan_a_word_oe_out,
    .chan_b_word_out, .chan_b_word_oe_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dap_capture dap_capture_inst (.clock_in, .word_in(chan_a_word_out),
    .word_oe_in(chan_a_word_oe_out), .line_out(line_a),
    .captured_out(cap_a));
  dap_capture dap_capture_b_inst (.clock_in, .word_in(chan_b_word_out),
    .word_oe_in(chan_b_word_oe_out), .line_out(line_b),
    .captured_out(cap_b));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic dap_pkg::dap_word_t code(input dap_pkg::dap_word_t v);
    return format_sel_in ? {~v[9], v[8:0]} : v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic drive(input dap_pkg::dap_word_t v);
    @(posedge clock_in);
    chan_a_sample_in <= v;
    chan_b_sample_in <= ~v;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] r);
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    chk(s_axi_bresp, r);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] r);
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask
  task automatic freeze(input bit use_pd);
    drive(10'h2c5);
    wait_n(10);
    if (use_pd) power_down_in <= 1;
    else sleep_in <= 1;
    wait_n(8);
    drive(10'h13a);
    wait_n(12);
    #1 chk(line_a, code(10'h2c5));
    chk(line_b, code(~10'h2c5));
    @(posedge clock_in);
    power_down_in <= 0;
    sleep_in <= 0;
    wait_n(14);
    #1 chk(line_a, code(10'h13a));
  endtask
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles >= 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    wait_n(6);
    resetn_in <= 1;
    output_enable_n_in <= 0;
    wait_n(8);
    #1 chk({chan_a_word_oe_out, chan_b_word_oe_out}, 20'hfffff);
    for (int t = 0; t < 2; t++) begin
      @(posedge clock_in);
      format_sel_in <= t[0];
      wait_n(8);
      for (int i = 0; i < 20; i++) begin
        drive(tbl[i % 8]);
        #1;
        if (i >= 6) chk(line_a, code(tbl[(i - 6) % 8]));
        if (i >= 6) chk(line_b, code(~tbl[(i - 6) % 8]));
        if (i >= 7) chk(cap_a, code(tbl[(i - 7) % 8]));
      end
    end
    freeze(1);
    freeze(0);
    axi_wr(4'h0, 32'h1, 2'h0);
    axi_rd(4'h0, 32'h1, 2'h0);
    axi_rd(4'h4, 32'h42, 2'h0);
    axi_wr(4'h0, 32'h2, 2'h0);
    axi_rd(4'h4, 32'h42, 2'h0);
    axi_wr(4'h0, 32'h0, 2'h0);
    axi_rd(4'h4, 32'h62, 2'h0);
    axi_rd(4'h8, {6'h0, code(~10'h13a), 6'h0, code(10'h13a)}, 2'h0);
    axi_rd(4'hc, 32'h0, 2'h2);
    axi_wr(4'h4, 32'h3, 2'h2);
    s_axi_wstrb <= 4'h0;
    axi_wr(4'h0, 32'h3, 2'h0);
    s_axi_wstrb <= 4'hf;
    axi_rd(4'h0, 32'h0, 2'h0);
    output_enable_n_in <= 1;
    wait_n(8);
    #1 chk({chan_a_word_oe_out, chan_b_word_oe_out}, 20'h0);
    wrap_up();
  end
endmodule // testbench
